//--- rtl/radc_ctrl.sv
// restart and divider alignment control registers with sync sequencer
// What this block does
// - writing 1 to pll restart bit reruns startup from calibration, including sync
// - writing 1 to restart bit 0 launches soft reset from calibration step
// - soft reset bit clears itself once the reset is launched
// - soft reset relatches input straps only when relatch select asks
// - alignment bit 7 write sets bit and starts oscillator divider resync, unless bit 0 is written too or a full sync runs
// - oscillator resync bit reads 1 while resync runs, clears when done
// - bits 6:4 written 1 set and start resync of one fractional divider, unless bit 0 is written too or a full sync runs
// - each fractional bit stays 1 until its own divider is done
// - alignment bit 0 starts full divider sync and clears itself afterwards
// - full sync order: oscillator, fractional 0, fractional 1, fractional 2
// - restart register at 0x0, alignment register at 0x4, module base 0xd00
`timescale 1ns/100ps
`default_nettype none
module radc_ctrl (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        relatch_sel_i,
    output logic             startup_req_o,
    output logic             startup_sync_o,
    output logic             relatch_o,
    input  wire logic        startup_done_i,
    output logic             osc_sync_req_o,
    input  wire logic        osc_sync_done_i,
    output logic      [2:0]  frac_sync_req_o,
    input  wire logic [2:0]  frac_sync_done_i
);
    typedef struct packed {
        logic                soft_rst;
        logic                apll_redo;
        logic                full_sync;
        logic                osc_busy;
        logic [2:0]          frac_busy;
        radc_pkg::radc_seq_t seq;
        logic                seq_issued;
        logic                st_req;
        logic                st_sync;
        logic                relatch;
        logic                osc_req;
        logic [2:0]          frac_req;
        logic [7:0]          rdata;
    } radc_state_t;

    radc_state_t r;
    radc_state_t next_r;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o) || (a == radc_pkg::BASE_ADDR + o);
    endfunction

    logic wr_rst;
    logic wr_aln;
    assign wr_rst = wr_i && hit(addr_i, radc_pkg::OFS_RESTART);
    assign wr_aln = wr_i && hit(addr_i, radc_pkg::OFS_ALIGN);

    always_comb begin
        next_r = r;
        next_r.st_req = 1'b0;
        next_r.relatch = 1'b0;
        next_r.osc_req = 1'b0;
        next_r.frac_req = 3'b000;
        // completions clear first so a new write in the same cycle wins
        // done pulses during a full sequence belong to the sequence, so
        // they must not clear manual busy bits left from an earlier write
        if (osc_sync_done_i && r.seq == radc_pkg::SEQ_IDLE) begin
            next_r.osc_busy = 1'b0;
        end
        for (int i = 0; i < radc_pkg::NUM_FRAC; i++) begin
            if (frac_sync_done_i[i] && r.seq == radc_pkg::SEQ_IDLE) begin
                next_r.frac_busy[i] = 1'b0;
            end
        end
        if (startup_done_i) begin
            next_r.apll_redo = 1'b0;
        end
        // soft reset bit lasts one cycle: the launch is the pulse itself
        if (r.soft_rst) begin
            next_r.soft_rst = 1'b0;
        end
        if (wr_rst) begin
            if (wdata_i[radc_pkg::BIT_SOFT_RESET]) begin
                next_r.soft_rst = 1'b1;
                next_r.st_req = 1'b1;
                next_r.relatch = relatch_sel_i;
            end
            if (wdata_i[radc_pkg::BIT_APLL_REDO]) begin
                next_r.apll_redo = 1'b1;
                next_r.st_req = 1'b1;
                next_r.st_sync = 1'b1;
            end else if (wdata_i[radc_pkg::BIT_SOFT_RESET]) begin
                next_r.st_sync = 1'b0;
            end
        end
        // full sequence walks one stage at a time, waiting for each done
        // manual writes are refused while it runs: a second request to a
        // divider already being aligned would break the fixed order
        unique case (r.seq)
            radc_pkg::SEQ_IDLE: begin
                if (wr_aln && wdata_i[radc_pkg::BIT_FULL_SYNC]) begin
                    next_r.full_sync = 1'b1;
                    next_r.seq = radc_pkg::SEQ_OSC;
                    next_r.seq_issued = 1'b0;
                end else if (wr_aln) begin
                    if (wdata_i[radc_pkg::BIT_OSC_SYNC]) begin
                        next_r.osc_busy = 1'b1;
                        next_r.osc_req = 1'b1;
                    end
                    for (int i = 0; i < radc_pkg::NUM_FRAC; i++) begin
                        if (wdata_i[radc_pkg::BIT_FRAC_LO + i]) begin
                            next_r.frac_busy[i] = 1'b1;
                            next_r.frac_req[i] = 1'b1;
                        end
                    end
                end
            end
            radc_pkg::SEQ_OSC: begin
                next_r.osc_req = !r.seq_issued;
                next_r.seq_issued = 1'b1;
                if (r.seq_issued && osc_sync_done_i) begin
                    next_r.seq = radc_pkg::SEQ_FRAC0;
                    next_r.seq_issued = 1'b0;
                end
            end
            radc_pkg::SEQ_FRAC0: begin
                next_r.frac_req[0] = !r.seq_issued;
                next_r.seq_issued = 1'b1;
                if (r.seq_issued && frac_sync_done_i[0]) begin
                    next_r.seq = radc_pkg::SEQ_FRAC1;
                    next_r.seq_issued = 1'b0;
                end
            end
            radc_pkg::SEQ_FRAC1: begin
                next_r.frac_req[1] = !r.seq_issued;
                next_r.seq_issued = 1'b1;
                if (r.seq_issued && frac_sync_done_i[1]) begin
                    next_r.seq = radc_pkg::SEQ_FRAC2;
                    next_r.seq_issued = 1'b0;
                end
            end
            radc_pkg::SEQ_FRAC2: begin
                next_r.frac_req[2] = !r.seq_issued;
                next_r.seq_issued = 1'b1;
                if (r.seq_issued && frac_sync_done_i[2]) begin
                    next_r.seq = radc_pkg::SEQ_IDLE;
                    next_r.full_sync = 1'b0;
                end
            end
            default: next_r.seq = radc_pkg::SEQ_IDLE;
        endcase
        // read data stands for one cycle only, zero otherwise
        next_r.rdata = 8'h00;
        if (rd_i && hit(addr_i, radc_pkg::OFS_RESTART)) begin
            next_r.rdata = {6'h00, r.apll_redo, r.soft_rst};
        end else if (rd_i && hit(addr_i, radc_pkg::OFS_ALIGN)) begin
            next_r.rdata = {r.osc_busy, r.frac_busy, 3'h0, r.full_sync};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r <= '0;
            r.seq <= radc_pkg::SEQ_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o         = r.rdata;
    assign startup_req_o   = r.st_req;
    assign startup_sync_o  = r.st_sync;
    assign relatch_o       = r.relatch;
    assign osc_sync_req_o  = r.osc_req;
    assign frac_sync_req_o = r.frac_req;

    a_soft_selfclr: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.soft_rst |=> !r.soft_rst)
        else $error("soft reset bit did not self clear");
    a_soft_launch: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_rst && wdata_i[0] |=> startup_req_o && relatch_o == $past(relatch_sel_i))
        else $error("soft reset launch or relatch wrong");
    a_apll_sync: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_rst && wdata_i[1] |=> startup_req_o && startup_sync_o)
        else $error("pll restart did not request sync");
    a_osc_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && wr_aln && wdata_i[7] && !wdata_i[0]
        |=> osc_sync_req_o && r.osc_busy)
        else $error("oscillator resync not started");
    a_osc_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.osc_busy && !osc_sync_done_i |=> r.osc_busy)
        else $error("oscillator busy dropped early");
    a_frac_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && wr_aln && wdata_i[5] && !wdata_i[0]
        |=> frac_sync_req_o[1] && r.frac_busy[1])
        else $error("fractional resync not started");
    a_frac_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.frac_busy[0] && !frac_sync_done_i[0] |=> r.frac_busy[0])
        else $error("fractional busy dropped early");
    a_seq_order: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_FRAC0 && r.seq_issued && frac_sync_done_i[0]
        |=> r.seq == radc_pkg::SEQ_FRAC1 ##1 frac_sync_req_o == 3'b010)
        else $error("sequence order broken");
    a_full_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && wr_aln && wdata_i[0]
        |=> r.full_sync ##1 osc_sync_req_o)
        else $error("full sync did not start");
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && hit(addr_i, radc_pkg::OFS_ALIGN) |=> rdata_o[3:1] == 3'b000)
        else $error("reserved bits not zero");

    // restart register checks
    a_soft_read_one: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_rst && wdata_i[0] |=> r.soft_rst)
        else $error("soft reset bit not set by write");

    a_soft_no_sync: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_rst && wdata_i[0] && !wdata_i[1] |=> !startup_sync_o)
        else $error("soft reset asked for divider sync");

    a_apll_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.apll_redo && !startup_done_i |=> r.apll_redo)
        else $error("pll restart bit dropped early");

    a_apll_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        startup_done_i && !(wr_rst && wdata_i[1]) |=> !r.apll_redo)
        else $error("pll restart bit not cleared");

    a_relatch_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
        relatch_o |-> startup_req_o)
        else $error("relatch without startup request");

    a_relatch_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_rst && wdata_i[0] && !relatch_sel_i |=> !relatch_o)
        else $error("relatch despite select low");

    a_start_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
        startup_req_o |-> $past(wr_rst && (wdata_i[0] || wdata_i[1])))
        else $error("startup request without a write");

    // alignment register checks
    a_osc_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && osc_sync_done_i && !wr_aln
        |=> !r.osc_busy)
        else $error("oscillator busy not cleared");

    a_frac_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && frac_sync_done_i[2] && !wr_aln
        |=> !r.frac_busy[2])
        else $error("fractional busy not cleared");

    a_frac_indep: assert property (@(posedge clk_i) disable iff (!nrst_i)
        frac_sync_done_i == 3'b001 && r.frac_busy[1] |=> r.frac_busy[1])
        else $error("fractional bit cleared by other divider");

    a_frac_start0: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && wr_aln && wdata_i[4] && !wdata_i[0]
        |=> frac_sync_req_o[0] && r.frac_busy[0])
        else $error("fractional 0 resync not started");

    a_frac_start2: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_IDLE && wr_aln && wdata_i[6] && !wdata_i[0]
        |=> frac_sync_req_o[2] && r.frac_busy[2])
        else $error("fractional 2 resync not started");

    a_busy_refused: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq != radc_pkg::SEQ_IDLE && !r.osc_busy |=> !r.osc_busy)
        else $error("manual resync accepted mid sequence");

    // full sequence checks
    a_osc_to_frac0: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_OSC && r.seq_issued && osc_sync_done_i
        |=> r.seq == radc_pkg::SEQ_FRAC0 ##1 frac_sync_req_o == 3'b001)
        else $error("fractional 0 not next after oscillator");

    a_frac1_to_2: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_FRAC1 && r.seq_issued && frac_sync_done_i[1]
        |=> r.seq == radc_pkg::SEQ_FRAC2 ##1 frac_sync_req_o == 3'b100)
        else $error("fractional 2 not last");

    a_full_end: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq == radc_pkg::SEQ_FRAC2 && r.seq_issued && frac_sync_done_i[2]
        |=> r.seq == radc_pkg::SEQ_IDLE && !r.full_sync)
        else $error("full sync bit did not clear");

    a_full_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq != radc_pkg::SEQ_IDLE |-> r.full_sync)
        else $error("full sync bit low while running");

    a_one_stage: assert property (@(posedge clk_i) disable iff (!nrst_i)
        r.seq != radc_pkg::SEQ_IDLE
        |-> $onehot0({frac_sync_req_o, osc_sync_req_o}))
        else $error("two stages requested at once");

    // read path checks
    a_rsvd_restart: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && hit(addr_i, radc_pkg::OFS_RESTART) |=> rdata_o[7:2] == 6'h00)
        else $error("restart reserved bits not zero");

    a_rd_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data without a read");

    a_rd_align: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && hit(addr_i, radc_pkg::OFS_ALIGN)
        |=> rdata_o[0] == $past(r.full_sync))
        else $error("alignment read data wrong");
endmodule : radc_ctrl
`default_nettype wire

//--- rtl/radc_pkg.sv
// constants for the restart and divider alignment control block
package radc_pkg;
    localparam logic [11:0] BASE_ADDR      = 12'h0d00;
    localparam logic [11:0] OFS_RESTART    = 12'h0000;
    localparam logic [11:0] OFS_ALIGN      = 12'h0004;
    localparam logic [7:0]  RESTART_RST    = 8'h00;
    localparam logic [7:0]  ALIGN_RST      = 8'h00;
    localparam int          BIT_SOFT_RESET = 0;
    localparam int          BIT_APLL_REDO  = 1;
    localparam int          BIT_FULL_SYNC  = 0;
    localparam int          BIT_FRAC_LO    = 4;
    localparam int          BIT_OSC_SYNC   = 7;
    localparam int          NUM_FRAC       = 3;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_OSC,
        SEQ_FRAC0,
        SEQ_FRAC1,
        SEQ_FRAC2
    } radc_seq_t;
endpackage : radc_pkg

//--- verification/radc_ctrl_test.sv
// self-checking bench for the restart and divider alignment block
`timescale 1ns/100ps
`default_nettype none
module radc_ctrl_test;
    logic        clk_i            = 1'b0;
    logic        nrst_i           = 1'b0;
    logic [11:0] addr_i           = 12'h0000;
    logic [7:0]  wdata_i          = 8'h00;
    logic        wr_i             = 1'b0;
    logic        rd_i             = 1'b0;
    logic        relatch_sel_i    = 1'b1;
    logic        startup_done_i   = 1'b0;
    logic        osc_sync_done_i  = 1'b0;
    logic [2:0]  frac_sync_done_i = 3'h0;
    logic [7:0]  rdata_o;
    logic        startup_req_o;
    logic        startup_sync_o;
    logic        relatch_o;
    logic        osc_sync_req_o;
    logic [2:0]  frac_sync_req_o;
    int          n_mismatch       = 0;
    int          checks_done      = 0;
    int          n_start          = 0;
    int          n_relatch        = 0;
    logic [15:0] req_log          = 16'h0000;

    always #50 clk_i = ~clk_i;

    radc_ctrl i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .relatch_sel_i(relatch_sel_i), .startup_req_o(startup_req_o),
        .startup_sync_o(startup_sync_o), .relatch_o(relatch_o),
        .startup_done_i(startup_done_i), .osc_sync_req_o(osc_sync_req_o),
        .osc_sync_done_i(osc_sync_done_i), .frac_sync_req_o(frac_sync_req_o),
        .frac_sync_done_i(frac_sync_done_i)
    );

    // pulses are counted per cycle, so a stretched pulse shows up as extra
    always @(posedge clk_i) begin
        if (startup_req_o === 1'b1) n_start <= n_start + 1;
        if (relatch_o === 1'b1) n_relatch <= n_relatch + 1;
        if ({frac_sync_req_o, osc_sync_req_o} !== 4'h0)
            req_log <= {req_log[11:0], frac_sync_req_o, osc_sync_req_o};
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk({8'h00, rdata_o}, {8'h00, exp});
    endtask

    // v is {startup, frac[2:0], osc}; the wait lets each stage request first
    task done(input logic [4:0] v);
        repeat (4) @(posedge clk_i);
        {startup_done_i, frac_sync_done_i, osc_sync_done_i} <= v;
        @(posedge clk_i);
        {startup_done_i, frac_sync_done_i, osc_sync_done_i} <= 5'h00;
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        finish_test;
    end

    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(12'h000, 8'h00);
        rd(12'hd04, 8'h00);
        $display("test reset values done");
        wr(12'hd00, 8'h01);
        rd(12'hd00, 8'h00);
        chk(16'(n_start), 16'h0001);
        chk(16'(n_relatch), 16'h0001);
        chk({15'h0000, startup_sync_o}, 16'h0000);
        @(posedge clk_i);
        relatch_sel_i <= 1'b0;
        wr(12'h000, 8'hfe);
        rd(12'h000, 8'h02);
        chk({15'h0000, startup_sync_o}, 16'h0001);
        done(5'h10);
        rd(12'h000, 8'h00);
        wr(12'h000, 8'h01);
        // the pulse counter updates one edge after the request shows
        repeat (2) @(posedge clk_i);
        chk(16'(n_start), 16'h0003);
        chk(16'(n_relatch), 16'h0001);
        $display("test restart done");
        wr(12'hd04, 8'h8e);
        rd(12'hd04, 8'h80);
        done(5'h01);
        rd(12'h004, 8'h00);
        wr(12'h004, 8'h70);
        rd(12'h004, 8'h70);
        done(5'h04);
        rd(12'h004, 8'h50);
        done(5'h0a);
        rd(12'h004, 8'h00);
        chk({8'h00, req_log[7:0]}, 16'h001e);
        $display("test manual resync done");
        // a stray manual write mid-sequence must not disturb the order
        wr(12'hd04, 8'h01);
        rd(12'hd04, 8'h01);
        wr(12'hd04, 8'h80);
        done(5'h01);
        done(5'h02);
        done(5'h04);
        done(5'h08);
        repeat (3) @(posedge clk_i);
        rd(12'hd04, 8'h00);
        chk(req_log, 16'h1248);
        $display("test full sync done");
        finish_test;
    end
endmodule // radc_ctrl_test
`default_nettype wire
